// File: design/mitp_target.sv
`timescale 1ns/10ps
`include "mitp_consts.svh"
module mitp_target #(
  parameter int unsigned STARTUP_CYCLES = `MITP_STARTUP_MS * `MITP_CLK_KHZ,
  parameter int unsigned REFRESH_CYCLES = `MITP_REFRESH_MS * `MITP_CLK_KHZ
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  mitp_if.target                       bus_io,
  input  wire mitp_pkg::mitp_sel_type  addr_sel_i,
  input  wire logic                    feed_a_en_i,
  input  wire logic                    feed_b_en_i,
  input  wire logic                    primary_alarm_i,
  input  wire logic                    holdup_switch_i,
  input  wire logic                    hotswap_switch_i,
  input  wire logic                    output_above_thr_i,
  input  wire mitp_pkg::mitp_byte_type holdup_cap_voltage_i,
  input  wire mitp_pkg::mitp_byte_type output_current_i,
  input  wire mitp_pkg::mitp_byte_type feed_a_voltage_i,
  input  wire mitp_pkg::mitp_byte_type feed_b_voltage_i,
  input  wire mitp_pkg::mitp_byte_type temperature_i,
  output mitp_pkg::mitp_byte_type      index_pointer_o
);
  import mitp_pkg::*;
  if (STARTUP_CYCLES < 1 || REFRESH_CYCLES < 1) begin : g_chk
    $error("refresh counts must be at least one cycle");
  end
  // ----------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------
  logic [2:0] scl_q, sda_q;
  logic [2:0] sel_s1_q, sel_s2_q;
  logic       rise, fall, start, stop;
  always_ff @(posedge clk_i) begin
    scl_q <= {scl_q[1:0], bus_io.scl};
    sda_q <= {sda_q[1:0], bus_io.sda};
    sel_s1_q <= addr_sel_i;
    sel_s2_q <= sel_s1_q;
  end
  // bit 0 is the first synchroniser stage and is read only by bit 1
  assign rise  = scl_q[1] & ~scl_q[2];
  assign fall  = ~scl_q[1] & scl_q[2];
  assign start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  assign stop  = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
  // ----------------------------------------
  // monitored register snapshot
  // ----------------------------------------
  logic [31:0]   tmr_q, tmr_d;
  mitp_byte_type snap_q [6];
  mitp_byte_type snap_d [6];
  always_comb begin
    tmr_d = tmr_q - 32'h1;
    snap_d = snap_q;
    if (tmr_q == 32'h0) begin
      tmr_d = 32'(REFRESH_CYCLES - 1);
      snap_d[0] = {1'b0, output_above_thr_i, hotswap_switch_i, holdup_switch_i,
                   1'b0, primary_alarm_i, feed_b_en_i, feed_a_en_i};
      snap_d[1] = holdup_cap_voltage_i;
      snap_d[2] = output_current_i;
      snap_d[3] = feed_a_voltage_i;
      snap_d[4] = feed_b_voltage_i;
      snap_d[5] = temperature_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr_q <= 32'(STARTUP_CYCLES - 1);
      for (int i = 0; i < 6; i++) begin
        snap_q[i] <= 8'h00;
      end
    end else begin
      tmr_q <= tmr_d;
      snap_q <= snap_d;
    end
  end
  function automatic mitp_byte_type read_reg(input mitp_byte_type idx, input mitp_byte_type s [6]);
    unique case (idx)
      `MITP_IDX_STATUS:  read_reg = s[0];
      `MITP_IDX_HOLDUP:  read_reg = s[1];
      `MITP_IDX_CURRENT: read_reg = s[2];
      `MITP_IDX_FEED_A:  read_reg = s[3];
      `MITP_IDX_FEED_B:  read_reg = s[4];
      `MITP_IDX_TEMP:    read_reg = s[5];
      default:           read_reg = 8'h00;
    endcase
  endfunction
  function automatic mitp_byte_type ptr_inc(input mitp_byte_type p);
    ptr_inc = (p == `MITP_PTR_MAX) ? `MITP_PTR_MAX : p + 8'h01;
  endfunction
  // ----------------------------------------
  // link state machine
  // ----------------------------------------
  mitp_tgt_state_type st_q, st_d;
  mitp_byte_type      sh_q, sh_d, ptr_q, ptr_d, rdat;
  logic [3:0]         cnt_q, cnt_d;
  logic               rw_q, rw_d, first_q, first_d, ack_q, ack_d, oe_q, oe_d;
  logic [6:0]         own_addr;
  always_comb begin
    own_addr = {`MITP_ADDR_HI, sel_s2_q};
    rdat = read_reg(ptr_q, snap_q);
    st_d = st_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    cnt_d = cnt_q;
    rw_d = rw_q;
    first_d = first_q;
    ack_d = ack_q;
    oe_d = oe_q;
    if (stop) begin
      st_d = TGT_IDLE;
      oe_d = 1'b0;
    end else if (start) begin
      st_d = TGT_ADDR;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else begin
      unique case (st_q)
        TGT_IDLE: begin
          oe_d = 1'b0;
        end
        TGT_ADDR, TGT_WR: begin
          if (rise && cnt_q != 4'h8) begin
            sh_d = {sh_q[6:0], sda_q[2]};
            cnt_d = cnt_q + 4'h1;
          end
          if (fall && cnt_q == 4'h8) begin
            oe_d = 1'b1;
            if (st_q == TGT_WR) begin
              st_d = TGT_WACK;
              first_d = 1'b0;
              ptr_d = first_q ? sh_q : ptr_inc(ptr_q);
            end else if (sh_q[7:1] == own_addr) begin
              st_d = TGT_AACK;
              rw_d = sh_q[0];
            end else begin
              st_d = TGT_IDLE;
              oe_d = 1'b0;
            end
          end
        end
        TGT_AACK: begin
          if (fall) begin
            cnt_d = 4'h0;
            if (rw_q) begin
              st_d = TGT_RD;
              sh_d = rdat;
              ptr_d = ptr_inc(ptr_q);
              oe_d = ~rdat[7];
            end else begin
              st_d = TGT_WR;
              first_d = 1'b1;
              oe_d = 1'b0;
            end
          end
        end
        TGT_WACK: begin
          if (fall) begin
            st_d = TGT_WR;
            cnt_d = 4'h0;
            oe_d = 1'b0;
          end
        end
        TGT_RD: begin
          if (rise && cnt_q != 4'h8) begin
            cnt_d = cnt_q + 4'h1;
          end
          if (fall) begin
            if (cnt_q == 4'h8) begin
              st_d = TGT_MACK;
              oe_d = 1'b0;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
            end
          end
        end
        TGT_MACK: begin
          if (rise) begin
            ack_d = ~sda_q[2];
          end
          if (fall) begin
            if (ack_q) begin
              st_d = TGT_RD;
              cnt_d = 4'h0;
              sh_d = rdat;
              ptr_d = ptr_inc(ptr_q);
              oe_d = ~rdat[7];
            end else begin
              st_d = TGT_IDLE;
            end
          end
        end
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= TGT_IDLE;
      sh_q <= 8'h00;
      ptr_q <= `MITP_PTR_RESET;
      cnt_q <= 4'h0;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      ack_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      cnt_q <= cnt_d;
      rw_q <= rw_d;
      first_q <= first_d;
      ack_q <= ack_d;
      oe_q <= oe_d;
    end
  end
  assign bus_io.tgt_sda_o  = 1'b0;
  assign bus_io.tgt_sda_oe = oe_q;
  assign index_pointer_o   = ptr_q;
endmodule

// File: design/mitp_consts.svh
`ifndef MITP_CONSTS_SVH
`define MITP_CONSTS_SVH
// ----------------------------------------
// target address and index pointer
// ----------------------------------------
`define MITP_ADDR_HI      4'h5
`define MITP_PTR_RESET    8'h00
`define MITP_PTR_MAX      8'hff
// ----------------------------------------
// monitored register indexes
// ----------------------------------------
`define MITP_IDX_STATUS   8'h1e
`define MITP_IDX_HOLDUP   8'h1f
`define MITP_IDX_CURRENT  8'h21
`define MITP_IDX_FEED_A   8'h22
`define MITP_IDX_FEED_B   8'h23
`define MITP_IDX_TEMP     8'h28
// ----------------------------------------
// refresh timing
// ----------------------------------------
`define MITP_CLK_KHZ      125000
`define MITP_STARTUP_MS   300
`define MITP_REFRESH_MS   100
// ----------------------------------------
// controller wishbone map, fields and scl quarter period
// ----------------------------------------
`define MITP_WB_CMD       2'h0
`define MITP_WB_STATUS    2'h1
`define MITP_WB_RXDATA    2'h2
`define MITP_CMD_GO       0
`define MITP_CMD_READ     1
`define MITP_CMD_CNT_LO   2
`define MITP_CMD_ADDR_LO  8
`define MITP_CMD_PTR_LO   16
`define MITP_QUARTER      313
`endif

// File: design/mitp_pkg.sv
package mitp_pkg;
  typedef logic [7:0] mitp_byte_type;
  typedef logic [2:0] mitp_sel_type;
  typedef enum logic [6:0] {
    TGT_IDLE = 7'h01,
    TGT_ADDR = 7'h02,
    TGT_AACK = 7'h04,
    TGT_WR   = 7'h08,
    TGT_WACK = 7'h10,
    TGT_RD   = 7'h20,
    TGT_MACK = 7'h40
  } mitp_tgt_state_type;
  typedef enum logic [4:0] {
    CTL_IDLE  = 5'h01,
    CTL_START = 5'h02,
    CTL_DATA  = 5'h04,
    CTL_ACK   = 5'h08,
    CTL_STOP  = 5'h10
  } mitp_ctl_state_type;
endpackage

// File: design/mitp_if.sv
`timescale 1ns/10ps
interface mitp_if;
  logic tgt_sda_o;
  logic tgt_sda_oe;
  logic ctl_scl_o;
  logic ctl_scl_oe;
  logic ctl_sda_o;
  logic ctl_sda_oe;
  logic scl;
  logic sda;
  // pulled-up wires: any enabled low drive wins
  assign scl = ~(ctl_scl_oe & ~ctl_scl_o);
  assign sda = ~((ctl_sda_oe & ~ctl_sda_o) | (tgt_sda_oe & ~tgt_sda_o));
  modport target (input scl, input sda, output tgt_sda_o, output tgt_sda_oe);
  modport ctrl (input scl, input sda, output ctl_scl_o, output ctl_scl_oe, output ctl_sda_o, output ctl_sda_oe);
endinterface

// File: design/mitp_ctrl.sv
`timescale 1ns/10ps
`include "mitp_consts.svh"
module mitp_ctrl #(
  parameter int unsigned QUARTER = `MITP_QUARTER
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  mitp_if.ctrl             bus_io
);
  import mitp_pkg::*;
  if (QUARTER < 4 || QUARTER > 65536) begin : g_chk
    $error("QUARTER outside what the synchronisers and divider serve");
  end
  mitp_ctl_state_type st_q, st_d;
  logic [1:0]  ph_q, ph_d;
  logic [15:0] div_q, div_d;
  logic [2:0]  bit_q, bit_d, idx_q, idx_d;
  logic [7:0]  sh_q, sh_d;
  logic [31:0] rx_q, rx_d, rd_d;
  logic [23:0] cmd_q, cmd_d;
  logic        nack_q, nack_d, samp_q, samp_d, ack_q, ack_d;
  logic        scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
  logic        sda_s1_q, sda_s2_q;
  logic        wr_cmd, tick, rd, tx, last;
  logic [2:0]  last_idx;
  // ----------------------------------------
  // bus slave and byte engine
  // ----------------------------------------
  always_comb begin
    cmd_d = cmd_q;
    wr_cmd = wb_cyc_i & wb_stb_i & ~ack_q & wb_we_i & (wb_adr_i[3:2] == `MITP_WB_CMD);
    for (int i = 0; i < 3; i++) begin
      if (wr_cmd && wb_sel_i[i]) begin
        cmd_d[i*8 +: 8] = wb_dat_i[i*8 +: 8];
      end
    end
    ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
    rd_d = 32'h0000_0000;
    unique case (wb_adr_i[3:2])
      `MITP_WB_CMD:    rd_d = {8'h00, cmd_q[23:1], 1'b0};
      `MITP_WB_STATUS: rd_d = {30'h0, nack_q, st_q != CTL_IDLE};
      `MITP_WB_RXDATA: rd_d = rx_q;
      default:         rd_d = 32'h0000_0000;
    endcase
    rd = cmd_q[`MITP_CMD_READ];
    last_idx = {1'b0, cmd_q[`MITP_CMD_CNT_LO +: 2]} + 3'h1;
    last = idx_q == last_idx;
    tx = (idx_q == 3'h0) | ~rd;
    tick = div_q == 16'(QUARTER - 1);
    st_d = st_q;
    ph_d = ph_q;
    div_d = tick ? 16'h0000 : div_q + 16'h0001;
    bit_d = bit_q;
    idx_d = idx_q;
    sh_d = sh_q;
    rx_d = rx_q;
    nack_d = nack_q;
    samp_d = samp_q;
    if (tick) begin
      ph_d = ph_q + 2'h1;
    end
    unique case (st_q)
      CTL_IDLE: begin
        ph_d = 2'h0;
        if (wr_cmd && wb_sel_i[0] && wb_dat_i[`MITP_CMD_GO]) begin
          st_d = CTL_START;
          div_d = 16'h0000;
          idx_d = 3'h0;
          bit_d = 3'h0;
          nack_d = 1'b0;
          rx_d = 32'h0000_0000;
          sh_d = {cmd_d[`MITP_CMD_ADDR_LO +: 7], cmd_d[`MITP_CMD_READ]};
        end
      end
      CTL_START: begin
        if (tick && ph_q == 2'h3) begin
          st_d = CTL_DATA;
        end
      end
      CTL_DATA: begin
        if (tick && ph_q == 2'h2) begin
          samp_d = sda_s2_q;
        end
        if (tick && ph_q == 2'h3) begin
          sh_d = {sh_q[6:0], samp_q};
          bit_d = bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            st_d = CTL_ACK;
            if (!tx) begin
              rx_d = {rx_q[23:0], sh_q[6:0], samp_q};
            end
          end
        end
      end
      CTL_ACK: begin
        if (tick && ph_q == 2'h2 && tx) begin
          nack_d = sda_s2_q;
        end
        if (tick && ph_q == 2'h3) begin
          // the count field sets the data bytes of writes as well as reads
          if ((tx && nack_q) || last) begin
            st_d = CTL_STOP;
          end else begin
            st_d = CTL_DATA;
            idx_d = idx_q + 3'h1;
            bit_d = 3'h0;
            sh_d = rd ? 8'h00 : cmd_q[`MITP_CMD_PTR_LO +: 8];
          end
        end
      end
      CTL_STOP: begin
        if (tick && ph_q == 2'h3) begin
          st_d = CTL_IDLE;
        end
      end
    endcase
    // pin drive follows the next state so both pins move on one edge
    scl_oe_d = 1'b0;
    sda_oe_d = 1'b0;
    unique case (st_d)
      CTL_IDLE: begin
        scl_oe_d = 1'b0;
      end
      CTL_START: begin
        sda_oe_d = 1'b1;
        scl_oe_d = ph_d[1];
      end
      CTL_DATA: begin
        scl_oe_d = ph_d == 2'h0 || ph_d == 2'h3;
        sda_oe_d = ((idx_d == 3'h0) | ~rd) & ~sh_d[7];
      end
      CTL_ACK: begin
        scl_oe_d = ph_d == 2'h0 || ph_d == 2'h3;
        sda_oe_d = rd && idx_d != 3'h0 && idx_d != last_idx;
      end
      CTL_STOP: begin
        scl_oe_d = ph_d == 2'h0;
        sda_oe_d = ~ph_d[1];
      end
    endcase
  end
  always_ff @(posedge clk_i) begin
    sda_s1_q <= bus_io.sda;
    sda_s2_q <= sda_s1_q;
    if (rst_i) begin
      st_q <= CTL_IDLE;
      ph_q <= 2'h0;
      div_q <= 16'h0000;
      bit_q <= 3'h0;
      idx_q <= 3'h0;
      sh_q <= 8'h00;
      rx_q <= 32'h0000_0000;
      cmd_q <= 24'h00_0000;
      nack_q <= 1'b0;
      samp_q <= 1'b0;
      ack_q <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ph_q <= ph_d;
      div_q <= div_d;
      bit_q <= bit_d;
      idx_q <= idx_d;
      sh_q <= sh_d;
      rx_q <= rx_d;
      cmd_q <= cmd_d;
      nack_q <= nack_d;
      samp_q <= samp_d;
      ack_q <= ack_d;
      wb_dat_o <= rd_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
    end
  end
  assign wb_ack_o = ack_q;
  assign bus_io.ctl_scl_o = 1'b0;
  assign bus_io.ctl_sda_o = 1'b0;
  assign bus_io.ctl_scl_oe = scl_oe_q;
  assign bus_io.ctl_sda_oe = sda_oe_q;
endmodule

// File: bench/mitp_assertions.sv
`timescale 1ns/10ps
module mitp_assertions (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic tgt_sda_o,
  input  wire logic tgt_sda_oe,
  input  wire logic ctl_scl_o,
  input  wire logic ctl_scl_oe,
  input  wire logic ctl_sda_o,
  input  wire logic ctl_sda_oe,
  input  wire logic scl,
  input  wire logic sda
);
  // ----------------------------------------
  // bit tracking on the wire
  // ----------------------------------------
  logic       scl_q;
  logic       sda_q;
  logic       adr_q;
  logic       rd_q;
  logic       mt_q;
  logic [3:0] nb_q;
  logic [7:0] sh_q;
  wire        rise = scl & ~scl_q;
  wire        strt = scl & scl_q & sda_q & ~sda;
  wire        stp  = scl & scl_q & ~sda_q & sda;
  wire        ack  = rise & (nb_q == 4'h8);
  always_ff @(posedge clk_i) begin
    scl_q <= scl;
    sda_q <= sda;
    if (rst_i || strt) begin
      nb_q  <= 4'h0;
      adr_q <= 1'b1;
      mt_q  <= 1'b0;
    end else if (rise) begin
      sh_q  <= {sh_q[6:0], sda};
      nb_q  <= ack ? 4'h0 : nb_q + 4'h1;
      adr_q <= adr_q & ~ack;
      if (ack && adr_q) begin
        rd_q <= sh_q[0];
        mt_q <= tgt_sda_oe;
      end
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  tgt_od_a: assert property (tgt_sda_o == 1'b0) else $error("target drives sda high");
  ctl_od_a: assert property (ctl_scl_o == 1'b0 && ctl_sda_o == 1'b0)
    else $error("controller drives a line high");
  addr_ack_a: assert property (ack && adr_q && sh_q[7:4] != 4'h5 |-> !tgt_sda_oe)
    else $error("foreign address acknowledged");
  wr_ack_a: assert property (ack && !adr_q && mt_q && !rd_q |-> tgt_sda_oe)
    else $error("write byte not acknowledged");
  rd_rel_a: assert property (ack && !adr_q && rd_q |-> !tgt_sda_oe)
    else $error("target holds sda in controller ack slot");
  rd_tx_a: assert property (rise && nb_q inside {[1:7]} && !adr_q && rd_q && mt_q |-> !ctl_sda_oe)
    else $error("controller drives sda during read data");
  tgt_quiet_a: assert property (!adr_q && !mt_q |-> !tgt_sda_oe)
    else $error("unaddressed target drives sda");
  stop_rel_a: assert property (stp |-> !tgt_sda_oe [*8])
    else $error("target drives sda after stop");
  start_rel_a: assert property (strt |-> !tgt_sda_oe [*8])
    else $error("target drives sda after start");
  edge_low_a: assert property ($changed(tgt_sda_oe) |-> !scl && !scl_q)
    else $error("target sda drive changed with scl high");
endmodule

// File: bench/tb.sv
`timescale 1ns/10ps
module tb;
  import mitp_pkg::*;
  logic          clk_i   = 1'b0;
  logic          rst_i   = 1'b1;
  logic          wb_cyc  = 1'b0;
  logic          wb_stb  = 1'b0;
  logic          wb_we   = 1'b0;
  logic [3:0]    wb_adr  = 4'h0;
  logic [3:0]    wb_sel  = 4'h0;
  logic [31:0]   wb_wdat = 32'h0;
  logic [31:0]   seed    = 32'hded5;
  logic [31:0]   wb_dat_o;
  logic          wb_ack_o;
  mitp_sel_type  sel     = 3'h5;
  logic [5:0]    stat    = 6'h0;
  mitp_byte_type v [5]   = '{default: 8'h00};
  mitp_byte_type ptr;
  logic [63:0]   note;
  logic [63:0]   exq [$];
  int            mismatches  = 0;
  int            checks_done = 0;
  always #4 clk_i = ~clk_i;
  mitp_if bus_if ();
  mitp_ctrl #(.QUARTER(5)) mitp_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_sel_i(wb_sel), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .bus_io(bus_if));
  mitp_target #(.STARTUP_CYCLES(3000), .REFRESH_CYCLES(100)) mitp_target_i (.clk_i(clk_i), .rst_i(rst_i),
    .bus_io(bus_if), .addr_sel_i(sel), .feed_a_en_i(stat[0]), .feed_b_en_i(stat[1]), .primary_alarm_i(stat[2]),
    .holdup_switch_i(stat[3]), .hotswap_switch_i(stat[4]), .output_above_thr_i(stat[5]),
    .holdup_cap_voltage_i(v[0]), .output_current_i(v[1]), .feed_a_voltage_i(v[2]), .feed_b_voltage_i(v[3]),
    .temperature_i(v[4]), .index_pointer_o(ptr));
  mitp_assertions mitp_assertions_i (.clk_i(clk_i), .rst_i(rst_i), .tgt_sda_o(bus_if.tgt_sda_o),
    .tgt_sda_oe(bus_if.tgt_sda_oe), .ctl_scl_o(bus_if.ctl_scl_o), .ctl_scl_oe(bus_if.ctl_scl_oe),
    .ctl_sda_o(bus_if.ctl_sda_o), .ctl_sda_oe(bus_if.ctl_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int i = 0; i < 32; i++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction
  task automatic finish_test();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
    checks_done++;
    if ((got & msk) !== (exp & msk)) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_ptr(input mitp_byte_type exp);
    cmp({24'h0, ptr}, {24'h0, exp}, 32'hff);
  endtask
  task automatic rnd();
    seed = lfsr(seed);
    {stat, v[0], v[1], v[2]} <= seed[29:0];
    seed = lfsr(seed);
    {v[3], v[4]} <= seed[15:0];
  endtask
  // classic cycle; reads leave a note for the monitor
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [63:0] n);
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} <= {2'b11, w, a, 4'hf, d};
    if (!w) exq.push_back(n);
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    {wb_cyc, wb_stb} <= 2'b00;
  endtask
  // one link transfer: command, wait for idle, check status and read bytes
  task automatic xfer(input logic rd, input logic [1:0] cm, input logic [6:0] a, input mitp_byte_type p,
                      input logic nk, input logic [31:0] rx);
    wb(1'b1, 4'h0, {8'h00, p, 1'b0, a, 4'h0, cm, rd, 1'b1}, 64'h0);
    do wb(1'b0, 4'h4, 32'h0, 64'h0); while (wb_dat_o[0] !== 1'b0);
    wb(1'b0, 4'h4, 32'h0, {30'h0, nk, 1'b0, 32'h3});
    if (rd) wb(1'b0, 4'h8, 32'h0, {rx, 32'hffffffff});
  endtask
  // ----------------------------------------
  // monitor and watchdog
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we === 1'b0 && exq.size() > 0) begin
      note = exq.pop_front();
      if (note[31:0] != 32'h0) cmp(wb_dat_o, note[63:32], note[31:0]);
    end
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    mismatches++;
    finish_test();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rnd();
    @(posedge clk_i);
    cmp_ptr(8'h00);
    xfer(1'b0, 2'd0, {4'h5, sel}, 8'h1e, 1'b0, 32'h0);
    cmp_ptr(8'h1e);
    xfer(1'b1, 2'd1, {4'h5, sel}, 8'h00, 1'b0, 32'h0);
    cmp_ptr(8'h20);
    repeat (3000) @(posedge clk_i);
    xfer(1'b0, 2'd0, {4'h5, sel}, 8'h1e, 1'b0, 32'h0);
    xfer(1'b1, 2'd3, {4'h5, sel}, 8'h00, 1'b0, {1'b0, stat[5:3], 1'b0, stat[2:0], v[0], 8'h00, v[1]});
    cmp_ptr(8'h22);
    rnd();
    xfer(1'b0, 2'd0, {4'h5, sel}, 8'h21, 1'b0, 32'h0);
    xfer(1'b1, 2'd3, {4'h5, sel}, 8'h00, 1'b0, {v[1], v[2], v[3], 8'h00});
    cmp_ptr(8'h25);
    xfer(1'b0, 2'd2, {4'h5, sel}, 8'h1d, 1'b0, 32'h0);
    cmp_ptr(8'h1f);
    xfer(1'b1, 2'd0, {4'h5, sel}, 8'h00, 1'b0, {24'h0, v[0]});
    xfer(1'b0, 2'd1, {4'h5, sel}, 8'h30, 1'b0, 32'h0);
    cmp_ptr(8'h31);
    xfer(1'b0, 2'd0, {4'h5, sel}, 8'h28, 1'b0, 32'h0);
    xfer(1'b1, 2'd0, {4'h5, sel}, 8'h00, 1'b0, {24'h0, v[4]});
    xfer(1'b0, 2'd0, {4'h5, sel}, 8'hfe, 1'b0, 32'h0);
    xfer(1'b1, 2'd2, {4'h5, sel}, 8'h00, 1'b0, 32'h0);
    cmp_ptr(8'hff);
    xfer(1'b0, 2'd0, {4'h4, sel}, 8'h33, 1'b1, 32'h0);
    xfer(1'b0, 2'd0, {4'h5, sel ^ 3'h1}, 8'h33, 1'b1, 32'h0);
    cmp_ptr(8'hff);
    for (int i = 0; i < 8; i++) begin
      sel <= i[2:0];
      repeat (4) @(posedge clk_i);
      xfer(1'b0, 2'd0, {4'h5, i[2:0]}, {5'h08, i[2:0]}, 1'b0, 32'h0);
      cmp_ptr({5'h08, i[2:0]});
    end
    // reset in mid-run: pointer and snapshot start over
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    cmp_ptr(8'h00);
    xfer(1'b0, 2'd0, {4'h5, sel}, 8'h1e, 1'b0, 32'h0);
    xfer(1'b1, 2'd3, {4'h5, sel}, 8'h00, 1'b0, 32'h0);
    finish_test();
  end
endmodule
